// File: rtl/dcpm_pkg.sv
// Package with register map, reset values and timing constants of the pulse modulator
package dcpm_pkg;

    // ----------------------------------------
    // Register indices and byte addresses
    // ----------------------------------------
    localparam int unsigned ADDR_W         = 12;
    localparam logic [7:0]  IDX_DUTY_0     = 8'h_FC;
    localparam logic [7:0]  IDX_DUTY_1     = 8'h_FD;
    localparam logic [7:0]  IDX_PRESCALE   = 8'h_FE;
    localparam logic [ADDR_W-1:0] ADDR_DUTY_0   = {2'b00, IDX_DUTY_0, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DUTY_1   = {2'b00, IDX_DUTY_1, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PRESCALE = {2'b00, IDX_PRESCALE, 2'b00};

    // ----------------------------------------
    // Field layout and reset values
    // ----------------------------------------
    localparam int unsigned DATA_W         = 8;
    localparam int unsigned CHANNELS       = 2;
    localparam logic [7:0]  RST_DUTY       = 8'h_00;
    localparam logic [7:0]  RST_PRESCALE   = 8'h_00;

    // ----------------------------------------
    // Counter constants
    // ----------------------------------------
    localparam logic [7:0]  CNT_LAST       = 8'h_FE;
    localparam logic [7:0]  CNT_FIRST      = 8'h_00;
    localparam logic [7:0]  PRE_FIRST      = 8'h_00;

    // Register selector
    typedef enum logic [1:0]
    {
        DCPM_SEL_DUTY_0   = 2'b00,
        DCPM_SEL_DUTY_1   = 2'b01,
        DCPM_SEL_PRESCALE = 2'b10,
        DCPM_SEL_NONE     = 2'b11
    } dcpm_sel_t;

endpackage

// File: rtl/dcpm_top.sv
// Dual channel pulse width modulator with APB register access
// Behaviour
// [R1] Prescaler divides clock by 2 x (reload + 1); its tick advances the shared counter.
// [R2] Full output period is 2 x (reload + 1) x 255 clock periods.
// [R3] Ratio 00h gives constant high output; ratio FFh gives constant low output.
// [R4] Counter never reaches FFh, so FFh ratio keeps output low all period.
// [R5] New ratio value acts on the output at once, not at period end.
// [R6] The two modulated outputs are dedicated pins with no other function.
// [R7] Reading the prescaler register returns the reload; the running count is hidden.
// [R8] Reload value is an 8-bit register at index FEh.
// [R9] Channel zero ratio is an 8-bit register at index FCh.
// [R10] Channel one ratio is an 8-bit register at index FDh.
// [R11] Shared counter steps 0 through 254 then wraps to 0.
// [R12] Output low while ratio exceeds count, high when ratio is at or below count.
// [R13] One prescaler and one counter serve both channels.
// [R14] Reset clears prescaler, counter and all three registers.
`timescale 1ns/1ps

module dcpm_top
    import dcpm_pkg::*;
(
    input  wire logic                clock_i,
    input  wire logic                rst_i,
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [ADDR_W-1:0]   paddr_i,
    input  wire logic [31:0]         pwdata_i,
    input  wire logic [3:0]          pstrb_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    output logic      [CHANNELS-1:0] pulse_out_n_o
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic dcpm_sel_t decode(input logic [ADDR_W-1:0] addr);
        dcpm_sel_t sel;
        sel = DCPM_SEL_NONE;
        if (addr == ADDR_DUTY_0)
            sel = DCPM_SEL_DUTY_0;     // [R9]
        else if (addr == ADDR_DUTY_1)
            sel = DCPM_SEL_DUTY_1;     // [R10]
        else if (addr == ADDR_PRESCALE)
            sel = DCPM_SEL_PRESCALE;   // [R8]
        return sel;
    endfunction

    dcpm_sel_t             sel;
    logic                  wr_en;
    logic [DATA_W-1:0]     duty_q [CHANNELS];
    logic [DATA_W-1:0]     reload_q;
    logic                  half_q;
    logic [7:0]            pre_q;
    logic [7:0]            cnt_q;
    logic                  tick;
    logic [31:0]           rdata_d;

    assign sel       = decode(paddr_i);
    // Zero wait states: every access completes on its first access cycle
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & (sel == DCPM_SEL_NONE);
    assign wr_en     = psel_i & penable_i & pwrite_i & pstrb_i[0] & (sel != DCPM_SEL_NONE);

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            duty_q[0] <= RST_DUTY;  // [R14]
            duty_q[1] <= RST_DUTY;
            reload_q  <= RST_PRESCALE;
        end
        else if (wr_en)
        begin
            unique case (sel)
                DCPM_SEL_DUTY_0:   duty_q[0] <= pwdata_i[7:0];  // [R9]
                DCPM_SEL_DUTY_1:   duty_q[1] <= pwdata_i[7:0];  // [R10]
                DCPM_SEL_PRESCALE: reload_q  <= pwdata_i[7:0];  // [R8]
                DCPM_SEL_NONE:     ;
            endcase
        end
    end

    // ----------------------------------------
    // Read data, latched in the setup cycle
    // ----------------------------------------
    always_comb
    begin
        rdata_d = 32'h_0000_0000;
        unique case (sel)
            DCPM_SEL_DUTY_0:   rdata_d = {24'h_00_0000, duty_q[0]};
            DCPM_SEL_DUTY_1:   rdata_d = {24'h_00_0000, duty_q[1]};
            DCPM_SEL_PRESCALE: rdata_d = {24'h_00_0000, reload_q};  // [R7]
            DCPM_SEL_NONE:     rdata_d = 32'h_0000_0000;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            prdata_o <= 32'h_0000_0000;
        else if (psel_i & ~penable_i & ~pwrite_i)
            prdata_o <= rdata_d;
    end

    // ----------------------------------------
    // Shared prescaler and counter
    // ----------------------------------------
    // Fixed divide by two ahead of the reload stage sets the factor 2 in the period
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            half_q <= 1'b0;   // [R14]
        else
            half_q <= ~half_q;  // [R2]
    end

    assign tick = half_q & (pre_q >= reload_q);  // [R1]

    // Compare with >= so a reload lowered mid-count cannot strand the prescaler
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            pre_q <= PRE_FIRST;  // [R14]
        else if (tick)
            pre_q <= PRE_FIRST;  // [R1]
        else if (half_q)
            pre_q <= pre_q + 8'h_01;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_q <= CNT_FIRST;  // [R14]
        else if (tick)
            cnt_q <= (cnt_q == CNT_LAST) ? CNT_FIRST : cnt_q + 8'h_01;  // [R11] [R13]
    end

    // ----------------------------------------
    // Channel outputs
    // ----------------------------------------
    // Compare uses the live ratio register, so a new value shows one clock after the write
    generate
        for (genvar ch = 0; ch < CHANNELS; ch++)
        begin : g_chan
            always_ff @(posedge clock_i or posedge rst_i)
            begin
                if (rst_i)
                    pulse_out_n_o[ch] <= 1'b1;
                else
                    pulse_out_n_o[ch] <= ~(duty_q[ch] > cnt_q);  // [R12] [R3] [R4] [R5] [R6]
            end
        end
    endgenerate

endmodule

// File: verification/dcpm_properties.sv
// Port checker for the pulse modulator
`timescale 1ns/1ps
module dcpm_properties
    import dcpm_pkg::*;
(
    input wire logic                clock_i,
    input wire logic                rst_i,
    input wire logic                psel_i,
    input wire logic                penable_i,
    input wire logic                pwrite_i,
    input wire logic [ADDR_W-1:0]   paddr_i,
    input wire logic [31:0]         pwdata_i,
    input wire logic [3:0]          pstrb_i,
    input wire logic [31:0]         prdata_o,
    input wire logic                pready_o,
    input wire logic                pslverr_o,
    input wire logic [CHANNELS-1:0] pulse_out_n_o
);
    // ----------------
    // Assertions
    // ----------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire wr  = psel_i && penable_i && pwrite_i && pstrb_i[0];
    wire w0  = wr && paddr_i == ADDR_DUTY_0;
    wire w1  = wr && paddr_i == ADDR_DUTY_1;
    wire map = paddr_i inside {ADDR_DUTY_0, ADDR_DUTY_1, ADDR_PRESCALE};
    ready_high_a: assert property (pready_o) else $error("pready low");
    err_unmapped_a: assert property (psel_i && penable_i && !map |-> pslverr_o) else $error("no error");
    err_mapped_a: assert property (pslverr_o |-> psel_i && penable_i && !map) else $error("bad error");
    read_upper_a: assert property (prdata_o[31:8] == 24'h00_0000) else $error("upper bits set");
    read_hold_a: assert property (!$past(psel_i && !penable_i && !pwrite_i) |-> $stable(prdata_o))
        else $error("read data moved");
    full_low0_a: assert property (w0 && pwdata_i[7:0] == 8'hFF |-> ##2 !pulse_out_n_o[0]) else $error("ch0 high");
    zero_high0_a: assert property (w0 && pwdata_i[7:0] == 8'h00 |-> ##2 pulse_out_n_o[0]) else $error("ch0 low");
    full_low1_a: assert property (w1 && pwdata_i[7:0] == 8'hFF |-> ##2 !pulse_out_n_o[1]) else $error("ch1 high");
    zero_high1_a: assert property (w1 && pwdata_i[7:0] == 8'h00 |-> ##2 pulse_out_n_o[1]) else $error("ch1 low");
    cover property (w0);
    cover property (pslverr_o);
    cover property ($fell(pulse_out_n_o[1]));
endmodule

bind dcpm_top dcpm_properties i_props (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .pulse_out_n_o);

// File: verification/tb_dcpm_top.sv
// Self-checking bench for the pulse modulator
`timescale 1ns/1ps
module tb_dcpm_top import dcpm_pkg::*; ;
    // ----------------
    // Stimulus
    // ----------------
    logic clock_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
    logic [ADDR_W-1:0] paddr_i = '0, ad[3] = '{ADDR_DUTY_0, ADDR_DUTY_1, ADDR_PRESCALE};
    logic [31:0] pwdata_i = '0, prdata_o, r = 32'hb001;
    logic [3:0] pstrb_i = '0;
    logic [1:0] pulse_out_n_o, po, pa;
    logic [32:0] q[$];
    logic [7:0] dd[2];
    int fail_count = 0, total_checks = 0, cyc = 0, n, i, k;
    dcpm_top i_dut (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
        .prdata_o, .pready_o, .pslverr_o, .pulse_out_n_o);
    always #4 clock_i = ~clock_i;
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [32:0] s, input logic [32:0] e);
        total_checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("MISMATCH %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // Reads checked by this watcher, oldest note first
    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        if (cyc > 20000)
        begin
            fail_count++;
            complete_run;
        end
        if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1)
            chk({pslverr_o, prdata_o}, q.pop_front());
    end
    initial
    begin
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        @(negedge clock_i);
        chk({31'h0, pulse_out_n_o}, 33'h3);
        for (i = 0; i < 3; i++)
        begin
            r = nx(r);
            q.push_back(33'h0);
            apb(0, ad[i], 0, 4'h0);
            apb(1, ad[i], r, 4'h1);
            apb(1, ad[i], ~r, 4'h0);
            q.push_back({25'h0, r[7:0]});
            apb(0, ad[i], 0, 4'h0);
        end
        q.push_back({1'b1, 32'h0});
        apb(1, 12'h000, r, 4'h1);
        apb(0, 12'h000, 0, 4'h0);
        $display("registers done");
        r = nx(r);
        dd[0] = 8'h03;
        dd[1] = {1'b0, r[6:0]} | 8'h01;
        apb(1, ADDR_PRESCALE, 1, 4'h1);
        apb(1, ADDR_DUTY_0, {24'h0, dd[0]}, 4'h1);
        apb(1, ADDR_DUTY_1, {24'h0, dd[1]}, 4'h1);
        for (k = 0; k < 2; k++)
        begin
            while (pulse_out_n_o[k] !== 1'b1) @(negedge clock_i);
            while (pulse_out_n_o[k] !== 1'b0) @(negedge clock_i);
            for (n = 0; pulse_out_n_o[k] === 1'b0; n++) @(negedge clock_i);
            chk(33'(n), 33'(dd[k] * 4));
            for (; pulse_out_n_o[k] === 1'b1; n++) @(negedge clock_i);
            chk(33'(n), 33'd1020);
        end
        $display("timing done");
        for (k = 0; k < 2; k++)
        begin
            apb(1, ADDR_DUTY_0, k ? 0 : 255, 4'h1);
            apb(1, ADDR_DUTY_1, k ? 255 : 0, 4'h1);
            repeat (2) @(posedge clock_i);
            po = 2'b00;
            pa = 2'b11;
            repeat (1100)
            begin
                @(negedge clock_i);
                po = po | pulse_out_n_o;
                pa = pa & pulse_out_n_o;
            end
            chk({29'h0, po, pa}, k ? 33'h5 : 33'ha);
        end
        $display("levels done");
        complete_run;
    end
endmodule
